/* shared/rmsd_pkg.sv */
// Constants and types shared by the detector readout design files
// Function
// - Convert strobe rising edge starts one conversion
// - Converter powers down after each conversion
// - Serial output driven only while strobe low
// - Serial output high impedance after strobe rise
// - Result shifted out most significant bit first
// - Zeros follow the twelve result bits
// - Next bit on each shift clock fall
// - Detector enable high on, low off
// - Pull-down keeps floating enable low
// - Twelve-bit code proportional to power dBm
// - Straight binary code, saturating at both ends
// - Strobe fall wakes converter, starts acquisition
package rmsd_pkg;

	localparam int unsigned CODE_W     = 12;
	localparam int unsigned LEVEL_W    = 14;
	localparam int unsigned CNT_W      = 4;
	localparam int unsigned FIFO_DEPTH = 8;

	localparam logic [CODE_W-1:0]  CODE_ALL_ONES  = 12'hfff;
	localparam logic [CODE_W-1:0]  CODE_ZERO      = 12'h000;
	localparam logic [LEVEL_W-1:0] LEVEL_ZERO     = 14'h0000;
	localparam logic [CNT_W-1:0]   BITS_PER_WORD  = 4'hc;
	localparam logic [CNT_W-1:0]   LAST_BIT_INDEX = 4'hb;

	// Timing, in the unit printed, and derived cycle counts (rounded up)
	localparam int unsigned SYS_CLK_MHZ  = 20;
	localparam int unsigned CONVERT_STROBE_TIME_NS = 1600;
	localparam int unsigned ACQ_TIME_NS  = 400;
	localparam int unsigned CONVERT_STROBE_CYCLES  =
		(CONVERT_STROBE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int unsigned ACQ_CYCLES   =
		(ACQ_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int unsigned TMR_W        = 8;

	typedef enum logic [4:0] {
		ST_SLEEP   = 5'b00001,
		ST_ACQUIRE = 5'b00010,
		ST_READY   = 5'b00100,
		ST_CONVERT = 5'b01000,
		ST_DONE    = 5'b10000
	} rmsd_state_t;

endpackage : rmsd_pkg

/* shared/rmsd_stream_if.sv */
// Valid/ready word stream between the converter, the FIFO and the hold
`timescale 1ns/1ps
`default_nettype none
interface rmsd_stream_if #(
	parameter int unsigned W = 12
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : rmsd_stream_if
`default_nettype wire

/* verilog/rmsd_fifo.sv */
// Synchronous result FIFO, flip-flop storage
`timescale 1ns/1ps
`default_nettype none
module rmsd_fifo #(
	parameter int unsigned WIDTH = 12,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input  wire logic  i_sys_clk,
	input  wire logic  i_reset,
	// Fill and drain sides
	rmsd_stream_if.snk in_s,
	rmsd_stream_if.src out_s
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
	localparam logic [AW:0] LEVEL_ONE  = (AW+1)'(1);
	localparam logic [AW-1:0] PTR_ONE  = AW'(1);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    wr_ptr_nxt;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW-1:0]    rd_ptr_nxt;
	logic [AW:0]      level_r;
	logic [AW:0]      level_nxt;
	logic             push;
	logic             pop;

	assign in_s.ready  = (level_r != FULL_LEVEL);
	assign out_s.valid = (level_r != '0);
	assign out_s.data  = mem_r[rd_ptr_r];
	assign push = in_s.valid & in_s.ready;
	assign pop  = out_s.valid & out_s.ready;

	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		level_nxt  = level_r;
		if (push) begin
			wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + PTR_ONE;
		end
		if (pop) begin
			rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PTR_ONE;
		end
		if (push && !pop) begin
			level_nxt = level_r + LEVEL_ONE;
		end else if (pop && !push) begin
			level_nxt = level_r - LEVEL_ONE;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			level_r  <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			level_r  <= level_nxt;
		end
	end

	// Storage needs no reset; level gates every read
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_s.data;
		end
	end

endmodule : rmsd_fifo
`default_nettype wire

/* verilog/rmsd_link_shift.sv */
// Shift-clock side: counts falling edges and picks the bit on the pin
`timescale 1ns/1ps
`default_nettype none
module rmsd_link_shift (
	// Link clock and strobe
	input  wire logic                         i_shift_clk,
	input  wire logic                         i_convert_strobe,
	// Held result, static for the whole frame
	input  wire logic [rmsd_pkg::CODE_W-1:0]  i_word,
	// Bit for the pin
	output logic                              o_bit
);
	logic [rmsd_pkg::CNT_W-1:0] bit_cnt_r;
	logic [rmsd_pkg::CNT_W-1:0] bit_cnt_nxt;
	logic [rmsd_pkg::CNT_W-1:0] bit_idx;

	// Saturates after the word so trailing clocks give zeros
	always_comb begin
		bit_cnt_nxt = bit_cnt_r;
		if (bit_cnt_r != rmsd_pkg::BITS_PER_WORD) begin
			bit_cnt_nxt = bit_cnt_r + 4'h1;
		end
	end

	// Strobe high clears the count with no link edge needed: the shift
	// clock may be stopped between frames
	always_ff @(negedge i_shift_clk or posedge i_convert_strobe) begin
		if (i_convert_strobe) begin
			bit_cnt_r <= '0;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
		end
	end

	assign bit_idx = rmsd_pkg::LAST_BIT_INDEX - bit_cnt_r;
	// First bit shows as soon as the strobe falls, ahead of any edge
	assign o_bit = (bit_cnt_r == rmsd_pkg::BITS_PER_WORD) ? 1'b0
		: i_word[bit_idx];

endmodule : rmsd_link_shift
`default_nettype wire

/* verilog/rmsd_top.sv */
// Power detector converter control and serial result readout
`timescale 1ns/1ps
`default_nettype none
module rmsd_top #(
	parameter int unsigned CONVERT_STROBE_CYCLES = rmsd_pkg::CONVERT_STROBE_CYCLES,
	parameter int unsigned ACQ_CYCLES  = rmsd_pkg::ACQ_CYCLES,
	parameter int unsigned FIFO_DEPTH  = rmsd_pkg::FIFO_DEPTH
) (
	// System clock and reset
	input  wire logic                              i_sys_clk,
	input  wire logic                              i_reset,
	// Serial link pins
	input  wire logic                              i_shift_clk,
	input  wire logic                              i_convert_strobe,
	output logic                                   o_serial_result_out,
	output logic                                   o_serial_result_out_oe,
	// Detector
	input  wire logic                              i_det_enable,
	input  wire logic signed [rmsd_pkg::LEVEL_W-1:0] i_det_level,
	output logic                                   o_det_power_on,
	// Converter status
	output logic                                   o_adc_awake,
	output logic                                   o_converting,
	output logic                                   o_result_pending
);
	localparam logic [rmsd_pkg::TMR_W-1:0] CONVERT_STROBE_LAST =
		rmsd_pkg::TMR_W'(CONVERT_STROBE_CYCLES - 1);
	localparam logic [rmsd_pkg::TMR_W-1:0] ACQ_LAST  =
		rmsd_pkg::TMR_W'(ACQ_CYCLES - 1);
	localparam logic [rmsd_pkg::TMR_W-1:0] TMR_ONE   = 8'h01;
	localparam logic signed [rmsd_pkg::LEVEL_W-1:0] LEVEL_FULL =
		14'sh0fff;

	// Pin synchronisers
	logic strb_meta_r;
	logic strb_sync_r;
	logic strb_prev_r;
	logic en_meta_r;
	logic en_sync_r;

	// Converter state
	rmsd_pkg::rmsd_state_t state_r;
	rmsd_pkg::rmsd_state_t state_nxt;
	logic [rmsd_pkg::TMR_W-1:0]  tmr_r;
	logic [rmsd_pkg::TMR_W-1:0]  tmr_nxt;
	logic signed [rmsd_pkg::LEVEL_W-1:0] held_level_r;
	logic signed [rmsd_pkg::LEVEL_W-1:0] held_level_nxt;
	logic [rmsd_pkg::CODE_W-1:0] code_r;
	logic [rmsd_pkg::CODE_W-1:0] code_nxt;

	// Readout hold
	logic [rmsd_pkg::CODE_W-1:0] hold_word_r;
	logic [rmsd_pkg::CODE_W-1:0] hold_word_nxt;
	logic                        hold_fresh_r;
	logic                        hold_fresh_nxt;

	// Registered outputs
	logic oe_r;
	logic oe_nxt;
	logic det_on_r;
	logic det_on_nxt;
	logic awake_r;
	logic awake_nxt;
	logic convert_strobe_r;
	logic convert_strobe_nxt;
	logic pend_r;
	logic pend_nxt;

	logic strb_rise;
	logic strb_fall;
	logic [rmsd_pkg::CODE_W-1:0] link_word;
	logic                        link_bit;

	rmsd_stream_if #(.W(rmsd_pkg::CODE_W)) res_in ();
	rmsd_stream_if #(.W(rmsd_pkg::CODE_W)) res_out ();

	assign strb_rise = strb_sync_r & ~strb_prev_r;
	assign strb_fall = ~strb_sync_r & strb_prev_r;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			// Idle level of the strobe is high; a low reset value would
			// read as a rising edge and start a conversion unasked
			strb_meta_r <= 1'b1;
			strb_sync_r <= 1'b1;
			strb_prev_r <= 1'b1;
			en_meta_r   <= 1'b0;
			en_sync_r   <= 1'b0;
		end else begin
			strb_meta_r <= i_convert_strobe;
			strb_sync_r <= strb_meta_r;
			strb_prev_r <= strb_sync_r;
			en_meta_r   <= i_det_enable;
			en_sync_r   <= en_meta_r;
		end
	end

	// Converter sequence
	always_comb begin
		state_nxt      = state_r;
		tmr_nxt        = tmr_r;
		held_level_nxt = held_level_r;
		code_nxt       = code_r;
		case (state_r)
			rmsd_pkg::ST_SLEEP: begin
				if (strb_rise) begin
					state_nxt      = rmsd_pkg::ST_CONVERT;
					tmr_nxt        = '0;
					held_level_nxt = held_level_r;
				end else if (strb_fall) begin
					state_nxt = rmsd_pkg::ST_ACQUIRE;
					tmr_nxt   = '0;
				end
			end
			rmsd_pkg::ST_ACQUIRE: begin
				// Tracks the input; an early edge converts what it has
				held_level_nxt = det_on_r ? i_det_level
					: rmsd_pkg::LEVEL_ZERO;
				if (strb_rise) begin
					state_nxt = rmsd_pkg::ST_CONVERT;
					tmr_nxt   = '0;
				end else if (tmr_r == ACQ_LAST) begin
					state_nxt = rmsd_pkg::ST_READY;
				end else begin
					tmr_nxt = tmr_r + TMR_ONE;
				end
			end
			rmsd_pkg::ST_READY: begin
				held_level_nxt = det_on_r ? i_det_level
					: rmsd_pkg::LEVEL_ZERO;
				if (strb_rise) begin
					state_nxt = rmsd_pkg::ST_CONVERT;
					tmr_nxt   = '0;
				end
			end
			rmsd_pkg::ST_CONVERT: begin
				if (tmr_r == CONVERT_STROBE_LAST) begin
					state_nxt = rmsd_pkg::ST_DONE;
					// Package zero is unsigned; cast keeps the compare signed
					if (held_level_r < $signed(rmsd_pkg::LEVEL_ZERO)) begin
						code_nxt = rmsd_pkg::CODE_ZERO;
					end else if (held_level_r > LEVEL_FULL) begin
						code_nxt = rmsd_pkg::CODE_ALL_ONES;
					end else begin
						code_nxt = held_level_r[rmsd_pkg::CODE_W-1:0];
					end
				end else begin
					tmr_nxt = tmr_r + TMR_ONE;
				end
			end
			rmsd_pkg::ST_DONE: begin
				// Waits here while the FIFO is full
				if (res_in.ready) begin
					state_nxt = rmsd_pkg::ST_SLEEP;
				end
			end
			default: begin
				state_nxt = rmsd_pkg::ST_SLEEP;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_r      <= rmsd_pkg::ST_SLEEP;
			tmr_r        <= '0;
			held_level_r <= rmsd_pkg::LEVEL_ZERO;
			code_r       <= rmsd_pkg::CODE_ZERO;
		end else begin
			state_r      <= state_nxt;
			tmr_r        <= tmr_nxt;
			held_level_r <= held_level_nxt;
			code_r       <= code_nxt;
		end
	end

	assign res_in.valid = (state_r == rmsd_pkg::ST_DONE);
	assign res_in.data  = code_r;

	rmsd_fifo #(
		.WIDTH (rmsd_pkg::CODE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.in_s      (res_in),
		.out_s     (res_out)
	);

	// Hold only changes while the strobe is high, so the link side sees
	// a static word for the whole low phase
	assign res_out.ready = strb_sync_r & strb_prev_r & ~hold_fresh_r;

	always_comb begin
		hold_word_nxt  = hold_word_r;
		hold_fresh_nxt = hold_fresh_r;
		if (res_out.valid && res_out.ready) begin
			hold_word_nxt  = res_out.data;
			hold_fresh_nxt = 1'b1;
		end else if (strb_fall) begin
			hold_fresh_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			hold_word_r  <= rmsd_pkg::CODE_ZERO;
			hold_fresh_r <= 1'b0;
		end else begin
			hold_word_r  <= hold_word_nxt;
			hold_fresh_r <= hold_fresh_nxt;
		end
	end

	assign link_word = hold_word_r;

	rmsd_link_shift u_link (
		.i_shift_clk      (i_shift_clk),
		.i_convert_strobe (i_convert_strobe),
		.i_word           (link_word),
		.o_bit            (link_bit)
	);

	// Output and status flops
	always_comb begin
		oe_nxt     = ~strb_sync_r;
		// Pad pull-down sits outside; a floating pin samples low here
		det_on_nxt = en_sync_r;
		awake_nxt  = (state_nxt != rmsd_pkg::ST_SLEEP)
			&& (state_nxt != rmsd_pkg::ST_DONE);
		convert_strobe_nxt   = (state_nxt == rmsd_pkg::ST_CONVERT);
		pend_nxt   = hold_fresh_nxt;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			oe_r     <= 1'b0;
			det_on_r <= 1'b0;
			awake_r  <= 1'b0;
			convert_strobe_r   <= 1'b0;
			pend_r   <= 1'b0;
		end else begin
			oe_r     <= oe_nxt;
			det_on_r <= det_on_nxt;
			awake_r  <= awake_nxt;
			convert_strobe_r   <= convert_strobe_nxt;
			pend_r   <= pend_nxt;
		end
	end

	// Data bit leaves the link counter through a mux, so the first bit is
	// on the pin before any shift edge
	assign o_serial_result_out    = link_bit;
	assign o_serial_result_out_oe = oe_r;
	assign o_det_power_on         = det_on_r;
	assign o_adc_awake            = awake_r;
	assign o_converting           = convert_strobe_r;
	assign o_result_pending       = pend_r;

endmodule : rmsd_top
`default_nettype wire

/* dv/rmsd_top_assertions.sv */
// Checker on the top ports of the detector readout
`timescale 1ns/1ps
`default_nettype none
module rmsd_top_checker #(
	parameter int unsigned CONVERT_STROBE_CYCLES = 32
) (
	// Clock and pins
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_convert_strobe,
	input wire logic i_det_enable,
	// Status
	input wire logic o_serial_result_out_oe,
	input wire logic o_det_power_on,
	input wire logic o_adc_awake,
	input wire logic o_converting,
	input wire logic o_result_pending
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	logic [7:0] convert_strobe_cnt_r;
	// Counter avoids a long repetition in the length check
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !o_converting) begin
			convert_strobe_cnt_r <= 8'h00;
		end else begin
			convert_strobe_cnt_r <= convert_strobe_cnt_r + 8'h01;
		end
	end
	AST_OE_OFF: assert property (
		i_convert_strobe[*5] |-> !o_serial_result_out_oe)
		else $error("output enabled with strobe high");
	AST_OE_ON: assert property (
		(!i_convert_strobe && !i_reset)[*6] |-> o_serial_result_out_oe)
		else $error("output idle with strobe low");
	AST_CONVERT_STROBE_START: assert property (
		$rose(i_convert_strobe) && o_adc_awake && !o_converting
		|-> ##[2:6] o_converting) else $error("no conversion started");
	AST_CONVERT_STROBE_CAUSE: assert property (
		$rose(o_converting) |-> $past(i_convert_strobe, 2))
		else $error("conversion without strobe");
	AST_CONVERT_STROBE_LEN: assert property (
		$fell(o_converting) |-> convert_strobe_cnt_r == 8'(CONVERT_STROBE_CYCLES))
		else $error("conversion length wrong");
	AST_SLEEP: assert property (
		$fell(o_converting) |-> ##[1:3] !o_adc_awake)
		else $error("converter stayed awake");
	AST_PENDING: assert property (
		$fell(o_converting) && i_convert_strobe |-> ##[1:4] o_result_pending)
		else $error("result not held");
	AST_WAKE: assert property (
		$fell(i_convert_strobe) && !o_converting |-> ##[2:5] o_adc_awake)
		else $error("converter did not wake");
	AST_PEND_CLR: assert property (
		$fell(i_convert_strobe) |-> ##[2:5] !o_result_pending)
		else $error("pending not cleared");
	AST_DET_ON: assert property (
		(i_det_enable && !i_reset)[*4] |-> o_det_power_on)
		else $error("detector not on");
	AST_DET_OFF: assert property (
		(!i_det_enable)[*4] |-> !o_det_power_on)
		else $error("detector not off");
endmodule : rmsd_top_checker
bind rmsd_top rmsd_top_checker #(.CONVERT_STROBE_CYCLES(CONVERT_STROBE_CYCLES)) u_rmsd_top_checker (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset),
	.i_convert_strobe(i_convert_strobe), .i_det_enable(i_det_enable),
	.o_serial_result_out_oe(o_serial_result_out_oe),
	.o_det_power_on(o_det_power_on), .o_adc_awake(o_adc_awake),
	.o_converting(o_converting), .o_result_pending(o_result_pending));
`default_nettype wire

/* dv/rmsd_host_model.sv */
// Host model: strobe, shift clock and frame capture
`timescale 1ns/1ps
`default_nettype none
module rmsd_host_model (
	// Sys clock for pacing, serial pin in
	input  wire logic i_sys_clk,
	input  wire logic i_sdo,
	input  wire logic i_sdo_oe,
	// Pins driven by the host
	output logic      o_shift_clk,
	output logic      o_convert_strobe
);
	// Shift clock stands still low between frames
	initial begin
		o_shift_clk = 1'b0;
		o_convert_strobe = 1'b1;
	end
	task automatic strobe(input logic lvl);
		@(posedge i_sys_clk);
		#2 o_convert_strobe = lvl;
	endtask : strobe
	// Strobe stays low for the whole frame
	task automatic read_frame(output logic [15:0] bits, output logic oe_ok);
		oe_ok = 1'b1;
		repeat (5) @(posedge i_sys_clk);
		for (int i = 15; i >= 0; i--) begin
			#6;
			bits[i] = i_sdo;
			oe_ok = oe_ok & i_sdo_oe;
			o_shift_clk = 1'b1;
			#6 o_shift_clk = 1'b0;
		end
	endtask : read_frame
endmodule : rmsd_host_model
`default_nettype wire

/* dv/rmsd_top_tb.sv */
// Self-checking bench for the detector readout top
`timescale 1ns/1ps
`default_nettype none
module rmsd_top_tb;
	localparam int unsigned CONVERT_STROBE_N = 4;
	logic                                i_sys_clk;
	logic                                i_reset;
	logic                                shift_clk;
	logic                                strobe;
	logic                                det_en;
	logic                                serial_result_out;
	logic                                sdo_oe;
	logic                                det_on;
	logic                                awake;
	logic                                converting;
	logic                                pending;
	logic signed [rmsd_pkg::LEVEL_W-1:0] det_level;
	int                                  bad_count = 0;
	int                                  checks_done = 0;
	int                                  cycles = 0;

	rmsd_top #(.CONVERT_STROBE_CYCLES(CONVERT_STROBE_N), .ACQ_CYCLES(2)) u_rmsd_top (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_shift_clk(shift_clk),
		.i_convert_strobe(strobe), .o_serial_result_out(serial_result_out),
		.o_serial_result_out_oe(sdo_oe), .i_det_enable(det_en),
		.i_det_level(det_level), .o_det_power_on(det_on),
		.o_adc_awake(awake), .o_converting(converting),
		.o_result_pending(pending));
	rmsd_host_model u_rmsd_host_model (.i_sys_clk(i_sys_clk), .i_sdo(serial_result_out),
		.i_sdo_oe(sdo_oe), .o_shift_clk(shift_clk), .o_convert_strobe(strobe));

	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	task automatic conclude;
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	// Ceiling well above the roughly 400 cycles the tests need
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#2;
	endtask : tick
	// One full conversion, then a frame of 16 shifts: 12 bits and 4 zeros
	task automatic convert_strobe(input logic [13:0] lvl, input logic [11:0] code);
		logic [15:0] bits;
		logic        oe_ok;
		int          n;
		det_level = lvl;
		u_rmsd_host_model.strobe(1'b0);
		tick(10);
		u_rmsd_host_model.strobe(1'b1);
		for (n = 0; n < 80 && pending !== 1'b1; n++) tick(1);
		check({15'h0, pending}, 16'h0001);
		check({14'h0, awake, sdo_oe}, 16'h0000);
		u_rmsd_host_model.strobe(1'b0);
		u_rmsd_host_model.read_frame(bits, oe_ok);
		check(bits, {code, 4'h0});
		check({15'h0, oe_ok}, 16'h0001);
		// Extra conversion leaves the converter asleep, ready for a new level
		u_rmsd_host_model.strobe(1'b1);
		tick(CONVERT_STROBE_N + 12);
	endtask : convert_strobe
	task automatic test_enable;
		det_en = 1'b0;
		tick(5);
		check({15'h0, det_on}, 16'h0000);
		det_en = 1'b1;
		tick(5);
		check({15'h0, det_on}, 16'h0001);
		$display("test enable done");
	endtask : test_enable
	task automatic test_codes;
		logic [13:0] lv [6] = '{14'h0abc, 14'h0fff, 14'h1000, 14'h3fff,
			14'h0001, 14'h0800};
		logic [11:0] cd [6] = '{12'habc, 12'hfff, 12'hfff, 12'h000,
			12'h001, 12'h800};
		for (int i = 0; i < 6; i++) convert_strobe(lv[i], cd[i]);
		$display("test codes done");
	endtask : test_codes
	task automatic test_det_off;
		det_en = 1'b0;
		tick(5);
		convert_strobe(14'h0555, 12'h000);
		det_en = 1'b1;
		tick(5);
		$display("test detector off done");
	endtask : test_det_off
	initial begin
		i_reset = 1'b1;
		det_en = 1'b0;
		det_level = 14'h0000;
		tick(5);
		check({11'h0, sdo_oe, det_on, awake, converting, pending}, 16'h0);
		@(posedge i_sys_clk);
		#2 i_reset = 1'b0;
		tick(2);
		test_enable();
		test_codes();
		test_det_off();
		conclude();
	end
endmodule : rmsd_top_tb
`default_nettype wire
